// ### inc/amp_pkg.sv
// constants, field layout and types for the adaptive profile controller
// assumes a 100 MHz system clock and a word-aligned byte-address register port

package amp_pkg;

    // ------------------------------------------------------------
    // profiles
    // ------------------------------------------------------------
    localparam int PROF_W = 4;
    localparam int NUM_PROF = 13;
    localparam logic [3:0] PROF_MIN = 4'h0;
    localparam logic [3:0] PROF_MAX = 4'hc;
    localparam logic [3:0] PROF_LIGHT = 4'ha;

    typedef enum logic [3:0] {
        MOD_BPSK, MOD_QPSK, MOD_PSK8, MOD_QAM16, MOD_QAM32, MOD_QAM64,
        MOD_QAM128, MOD_QAM256, MOD_QAM512, MOD_QAM1024, MOD_QAM2048,
        MOD_QAM4096
    } amp_mod_t;

    typedef enum logic {REQ_IDLE, REQ_HOLD} amp_req_st_t;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PROF = 8'h04;
    localparam logic [7:0] OFF_THR = 8'h08;
    localparam logic [7:0] OFF_KEY = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [1:0] OFF_PWR_HI = 2'h1;

    localparam int CTRL_W = 8;
    localparam int CTRL_ADAPT = 0;
    localparam int CTRL_PROT = 1;
    localparam int CTRL_TRACK = 2;
    localparam int CTRL_XPIC = 3;
    localparam int CTRL_SFREQ = 4;
    localparam int CTRL_SSCR = 5;
    localparam int CTRL_SXPIC = 6;
    localparam int CTRL_FC = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    localparam int FIX_LSB = 0;
    localparam int MIN_LSB = 4;
    localparam int MAX_LSB = 8;
    localparam logic [11:0] PROF_RST = 12'hc00;

    localparam int UP_LSB = 0;
    localparam int DN_LSB = 8;
    localparam int BER_LSB = 16;
    localparam logic [23:0] THR_RST = 24'h8040c0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int REQ_GAP_NS = 1000;
    localparam int REQ_GAP_CYC = (REQ_GAP_NS + CLK_NS - 1) / CLK_NS;

endpackage

// ### core/amp_pwr_mem.sv
// per-profile transmit power table, one word per profile
// assumes a single clock; read data come out of a register

`timescale 1ns/100ps

module amp_pwr_mem #(
    parameter int DW = 8,
    parameter int DEPTH = 13,
    parameter int AW = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem_r [DEPTH];

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                mem_r[i] <= '0;
            end else if (wr_en && wr_addr == AW'(i)) begin
                mem_r[i] <= wr_data;
            end
        end
    end

    // out-of-range reads give zero power rather than garbage
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_data <= '0;
        end else if (rd_addr < AW'(DEPTH)) begin
            rd_data <= mem_r[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end

endmodule // amp_pwr_mem

// ### core/amp_ctrl.sv
// adaptive modulation profile controller for one carrier
// assumes modem-side inputs on clk_sys; far requests arrive as pulses

`timescale 1ns/100ps

module amp_ctrl #(
    parameter logic [31:0] ACT_KEY = 32'h5a5a0001, // arbitrary value
    parameter int PWR_W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic mse_valid,
    input wire logic [7:0] mse_level,
    input wire logic [7:0] ber_level,
    input wire logic far_req_up,
    input wire logic far_req_dn,
    input wire logic [3:0] far_tx_prof,
    input wire logic protect_active,
    input wire logic frame_sof,
    output logic req_up,
    output logic req_dn,
    output logic [3:0] tx_prof,
    output logic [3:0] tx_mod,
    output logic tx_fec_light,
    output logic [PWR_W-1:0] tx_pwr,
    output logic [3:0] rx_prof,
    output logic [3:0] rx_mod,
    output logic rx_fec_light,
    output logic adapt_on,
    output logic [2:0] qos_drop,
    output logic [3:0] fc_throttle,
    output logic xpic_alarm
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] lim(input logic [3:0] p);
        lim = (p > amp_pkg::PROF_MAX) ? amp_pkg::PROF_MAX : p;
    endfunction

    function automatic logic [3:0] mod_of(input logic [3:0] p);
        amp_pkg::amp_mod_t m;
        m = amp_pkg::amp_mod_t'(p);
        if (p > amp_pkg::PROF_LIGHT - 4'h1) begin
            m = amp_pkg::amp_mod_t'(p - 4'h1);
        end
        mod_of = 4'(m);
    endfunction

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    logic [amp_pkg::CTRL_W-1:0] ctrl_r;
    logic [11:0] prof_cfg_r;
    logic [23:0] thr_r;
    logic key_ok_r;
    logic [3:0] fix_p;
    logic [3:0] min_p;
    logic [3:0] max_p;
    logic adapt;
    logic prot;
    logic is_active;

    assign fix_p = lim(prof_cfg_r[amp_pkg::FIX_LSB +: 4]);
    assign min_p = lim(prof_cfg_r[amp_pkg::MIN_LSB +: 4]);
    assign max_p = lim(prof_cfg_r[amp_pkg::MAX_LSB +: 4]);
    // a key-less adaptive request quietly falls back to fixed
    assign adapt = ctrl_r[amp_pkg::CTRL_ADAPT] & key_ok_r;
    assign prot = ctrl_r[amp_pkg::CTRL_PROT];
    assign is_active = !prot || protect_active;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= amp_pkg::CTRL_RST;
            prof_cfg_r <= amp_pkg::PROF_RST;
            thr_r <= amp_pkg::THR_RST;
        end else if (reg_wr) begin
            if (reg_addr == amp_pkg::OFF_CTRL) begin
                ctrl_r <= reg_wdata[amp_pkg::CTRL_W-1:0];
            end else if (reg_addr == amp_pkg::OFF_PROF) begin
                prof_cfg_r <= reg_wdata[11:0];
            end else if (reg_addr == amp_pkg::OFF_THR) begin
                thr_r <= reg_wdata[23:0];
            end
        end
    end

    // any write to the key word re-judges it; a wrong key drops adaptive
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            key_ok_r <= 1'b0;
        end else if (reg_wr && reg_addr == amp_pkg::OFF_KEY) begin
            key_ok_r <= (reg_wdata == ACT_KEY);
        end
    end

    // ------------------------------------------------------------
    // power table port
    // ------------------------------------------------------------
    logic pwr_we;
    logic [PWR_W-1:0] pwr_rd;

    assign pwr_we = reg_wr && reg_addr[7:6] == amp_pkg::OFF_PWR_HI
        && reg_addr[1:0] == 2'h0;

    amp_pwr_mem #(
        .DW(PWR_W),
        .DEPTH(amp_pkg::NUM_PROF),
        .AW(amp_pkg::PROF_W)
    ) u_pwr (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_en(pwr_we),
        .wr_addr(reg_addr[5:2]),
        .wr_data(reg_wdata[PWR_W-1:0]),
        .rd_addr(tx_prof),
        .rd_data(pwr_rd)
    );

    // power follows the applied profile two cycles later
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_pwr <= '0;
        end else begin
            tx_pwr <= pwr_rd;
        end
    end

    // ------------------------------------------------------------
    // request engine (receive side)
    // ------------------------------------------------------------
    amp_pkg::amp_req_st_t req_st_r;
    logic [15:0] gap_r;
    logic bad_q;
    logic good_q;

    assign bad_q = ber_level >= thr_r[amp_pkg::BER_LSB +: 8]
        || mse_level < thr_r[amp_pkg::DN_LSB +: 8];
    assign good_q = mse_level > thr_r[amp_pkg::UP_LSB +: 8];

    // hold-off keeps one request in flight per gap; steps repeat after it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            req_st_r <= amp_pkg::REQ_IDLE;
            gap_r <= '0;
            req_up <= 1'b0;
            req_dn <= 1'b0;
        end else begin
            req_up <= 1'b0;
            req_dn <= 1'b0;
            case (req_st_r)
                amp_pkg::REQ_IDLE: begin
                    if (mse_valid && adapt && is_active) begin
                        if (bad_q) begin
                            req_dn <= 1'b1;
                            req_st_r <= amp_pkg::REQ_HOLD;
                            gap_r <= 16'(amp_pkg::REQ_GAP_CYC - 1);
                        end else if (good_q) begin
                            req_up <= 1'b1;
                            req_st_r <= amp_pkg::REQ_HOLD;
                            gap_r <= 16'(amp_pkg::REQ_GAP_CYC - 1);
                        end
                    end
                end
                amp_pkg::REQ_HOLD: begin
                    if (gap_r == 16'h0) begin
                        req_st_r <= amp_pkg::REQ_IDLE;
                    end else begin
                        gap_r <= gap_r - 16'h1;
                    end
                end
                default: begin
                    req_st_r <= amp_pkg::REQ_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // transmit profile
    // ------------------------------------------------------------
    logic [3:0] pend_r;
    logic [3:0] tx_nxt;

    always_comb begin
        tx_nxt = pend_r;
        if (!adapt) begin
            tx_nxt = fix_p;
        end else if (prot && !protect_active
                && !ctrl_r[amp_pkg::CTRL_TRACK]) begin
            tx_nxt = amp_pkg::PROF_MIN;
        end else if (pend_r < min_p) begin
            tx_nxt = min_p;
        end else if (pend_r > max_p) begin
            tx_nxt = max_p;
        end else if (far_req_dn && pend_r > min_p) begin
            tx_nxt = pend_r - 4'h1;
        end else if (far_req_up && pend_r < max_p) begin
            tx_nxt = pend_r + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pend_r <= amp_pkg::PROF_MIN;
        end else begin
            pend_r <= tx_nxt;
        end
    end

    // switching only on the frame marker keeps every frame in one profile
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_prof <= amp_pkg::PROF_MIN;
            tx_mod <= 4'h0;
            tx_fec_light <= 1'b0;
        end else if (frame_sof) begin
            tx_prof <= pend_r;
            tx_mod <= mod_of(pend_r);
            tx_fec_light <= (pend_r == amp_pkg::PROF_LIGHT);
        end
    end

    // ------------------------------------------------------------
    // receive profile
    // ------------------------------------------------------------
    logic [3:0] rx_src;
    logic rx_ok;

    assign rx_src = adapt ? far_tx_prof : fix_p;
    assign rx_ok = rx_src <= amp_pkg::PROF_MAX;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_prof <= amp_pkg::PROF_MIN;
            rx_mod <= 4'h0;
            rx_fec_light <= 1'b0;
        end else if (frame_sof && rx_ok) begin
            rx_prof <= rx_src;
            rx_mod <= mod_of(rx_src);
            rx_fec_light <= (rx_src == amp_pkg::PROF_LIGHT);
        end
    end

    // ------------------------------------------------------------
    // capacity coupling and status
    // ------------------------------------------------------------
    logic [3:0] loss;

    assign loss = (tx_prof >= max_p) ? 4'h0 : max_p - tx_prof;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            qos_drop <= 3'h0;
            fc_throttle <= 4'h0;
        end else begin
            qos_drop <= (loss > 4'h7) ? 3'h7 : loss[2:0];
            fc_throttle <= ctrl_r[amp_pkg::CTRL_FC] ? loss : 4'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            xpic_alarm <= 1'b0;
            adapt_on <= 1'b0;
        end else begin
            xpic_alarm <= ctrl_r[amp_pkg::CTRL_XPIC]
                && !(ctrl_r[amp_pkg::CTRL_SFREQ] && ctrl_r[amp_pkg::CTRL_SSCR]
                && ctrl_r[amp_pkg::CTRL_SXPIC] && !prot);
            adapt_on <= adapt;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0;
        end else if (reg_addr == amp_pkg::OFF_CTRL) begin
            reg_rdata <= {24'h0, ctrl_r};
        end else if (reg_addr == amp_pkg::OFF_PROF) begin
            reg_rdata <= {20'h0, prof_cfg_r};
        end else if (reg_addr == amp_pkg::OFF_THR) begin
            reg_rdata <= {8'h0, thr_r};
        end else if (reg_addr == amp_pkg::OFF_KEY) begin
            reg_rdata <= {31'h0, key_ok_r};
        end else if (reg_addr == amp_pkg::OFF_STAT) begin
            reg_rdata <= {18'h0, pend_r, xpic_alarm, adapt_on, rx_prof, tx_prof};
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule // amp_ctrl

// ### sim/amp_ctrl_monitor.sv
// port-level assertions for the adaptive profile controller
// assumes one clock domain and the control word layout of amp_pkg
`timescale 1ns/100ps

module amp_ctrl_monitor (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic mse_valid,
    input wire logic protect_active,
    input wire logic frame_sof,
    input wire logic req_up,
    input wire logic req_dn,
    input wire logic [3:0] tx_prof,
    input wire logic [3:0] tx_mod,
    input wire logic tx_fec_light,
    input wire logic [3:0] rx_prof,
    input wire logic [3:0] rx_mod,
    input wire logic rx_fec_light,
    input wire logic adapt_on,
    input wire logic [3:0] fc_throttle,
    input wire logic xpic_alarm
);
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_q_r;
    logic [7:0] gap_r;
    logic calm;

    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // shadow state
    // ------------------------------------------------------------
    // control word snooped off the write port, plus a one-cycle copy so
    // checks wait until any registered output has caught up
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= 8'h00;
            ctrl_q_r <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == amp_pkg::OFF_CTRL) begin
                ctrl_r <= reg_wdata[7:0];
            end
            ctrl_q_r <= ctrl_r;
        end
    end
    assign calm = ctrl_r == ctrl_q_r;

    // saturating, so a long idle span never wraps into a false gap
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gap_r <= 8'hff;
        end else if (req_up || req_dn) begin
            gap_r <= 8'h00;
        end else if (gap_r != 8'hff) begin
            gap_r <= gap_r + 8'h01;
        end
    end

    prof_range_a: assert property (tx_prof <= 4'hc && rx_prof <= 4'hc)
        else $error("profile code out of range");
    tx_map_a: assert property (tx_fec_light == (tx_prof == 4'ha) &&
        tx_mod == ((tx_prof <= 4'h9) ? tx_prof : tx_prof - 4'h1))
        else $error("transmit modulation does not match profile");
    rx_map_a: assert property (rx_fec_light == (rx_prof == 4'ha) &&
        rx_mod == ((rx_prof <= 4'h9) ? rx_prof : rx_prof - 4'h1))
        else $error("receive modulation does not match profile");
    prof_hold_a: assert property ($changed(tx_prof) || $changed(rx_prof) |-> $past(frame_sof))
        else $error("profile changed off a frame boundary");
    req_pulse_a: assert property (req_up || req_dn |=> !(req_up || req_dn) [*8])
        else $error("request pulse too long");
    req_gap_a: assert property (req_up || req_dn |-> gap_r >= 8'h64)
        else $error("requests too close together");
    req_cause_a: assert property (req_up || req_dn |->
        $past(mse_valid && adapt_on && (protect_active || !ctrl_r[1])))
        else $error("request without an eligible quality sample");
    adapt_gate_a: assert property (calm && !ctrl_r[0] |-> !adapt_on)
        else $error("adaptation on in fixed mode");
    xpic_alarm_a: assert property (calm |-> xpic_alarm ==
        (ctrl_r[3] && !(ctrl_r[4] && ctrl_r[5] && ctrl_r[6] && !ctrl_r[1])))
        else $error("cross-polar alarm wrong");
    fc_off_a: assert property (calm && !ctrl_r[7] |-> fc_throttle == 4'h0)
        else $error("flow control throttles while disabled");

    up_seen_c: cover property (req_up);
    dn_seen_c: cover property (req_dn);
    tx_step_c: cover property ($changed(tx_prof));
    alarm_c: cover property ($rose(xpic_alarm));
endmodule // amp_ctrl_monitor

bind amp_ctrl amp_ctrl_monitor mon (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .mse_valid(mse_valid),
    .protect_active(protect_active), .frame_sof(frame_sof), .req_up(req_up), .req_dn(req_dn),
    .tx_prof(tx_prof), .tx_mod(tx_mod), .tx_fec_light(tx_fec_light), .rx_prof(rx_prof),
    .rx_mod(rx_mod), .rx_fec_light(rx_fec_light), .adapt_on(adapt_on),
    .fc_throttle(fc_throttle), .xpic_alarm(xpic_alarm));

// ### sim/amp_far_model.sv
// remote modem model: far transmitter and far receiver request source
// assumes one clock; the bench commands when the far receiver asks
`timescale 1ns/100ps

module amp_far_model #(
    parameter logic [3:0] INIT = 4'h5
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic req_up,
    input wire logic req_dn,
    input wire logic send_up,
    input wire logic send_dn,
    input wire logic slow,
    input wire logic bad,
    output logic far_req_up,
    output logic far_req_dn,
    output logic [3:0] far_tx_prof
);
    logic [3:0] up_r;
    logic [3:0] dn_r;
    logic [3:0] prof_r;

    // slow answers three cycles later; slow only changes while idle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            up_r <= 4'h0;
            dn_r <= 4'h0;
        end else begin
            up_r <= {up_r[2:0], send_up};
            dn_r <= {dn_r[2:0], send_dn};
        end
    end
    assign far_req_up = slow ? up_r[3] : up_r[0];
    assign far_req_dn = slow ? dn_r[3] : dn_r[0];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prof_r <= INIT;
        end else if (req_dn && prof_r != 4'h0) begin
            prof_r <= prof_r - 4'h1;
        end else if (req_up && prof_r < 4'hc) begin
            prof_r <= prof_r + 4'h1;
        end
    end
    // a corrupt code appears only on command
    assign far_tx_prof = bad ? 4'hf : prof_r;
endmodule // amp_far_model

// ### sim/amp_ctrl_tb.sv
// self-checking bench for the adaptive profile controller
// assumes amp_far_model on the link side and amp_ctrl_monitor bound in
`timescale 1ns/100ps

module amp_ctrl_tb;
    localparam logic [31:0] KEY_V = 32'h3c3c0007; // arbitrary value
    logic clk_sys, rstn, reg_wr, reg_rd, mse_valid, far_req_up, far_req_dn, frame_sof;
    logic protect_active, req_up, req_dn, tx_fec_light, rx_fec_light, adapt_on, xpic_alarm;
    logic send_up, send_dn, slow, bad, rd_d;
    logic [7:0] reg_addr, mse_level, ber_level, tx_pwr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [3:0] far_tx_prof, tx_prof, tx_mod, rx_prof, rx_mod, fc_throttle;
    logic [2:0] qos_drop;
    logic [31:0] exp_q[$], msk_q[$];
    logic [1:0] rq_q[$];
    logic [7:0] pw[13];
    int errors, checked;

    amp_ctrl #(.ACT_KEY(KEY_V)) uut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mse_valid(mse_valid), .mse_level(mse_level), .ber_level(ber_level),
        .far_req_up(far_req_up), .far_req_dn(far_req_dn), .far_tx_prof(far_tx_prof),
        .protect_active(protect_active), .frame_sof(frame_sof), .req_up(req_up),
        .req_dn(req_dn), .tx_prof(tx_prof), .tx_mod(tx_mod), .tx_fec_light(tx_fec_light),
        .tx_pwr(tx_pwr), .rx_prof(rx_prof), .rx_mod(rx_mod), .rx_fec_light(rx_fec_light),
        .adapt_on(adapt_on), .qos_drop(qos_drop), .fc_throttle(fc_throttle),
        .xpic_alarm(xpic_alarm));
    amp_far_model far (.clk_sys(clk_sys), .rstn(rstn), .req_up(req_up), .req_dn(req_dn),
        .send_up(send_up), .send_dn(send_dn), .slow(slow), .bad(bad),
        .far_req_up(far_req_up), .far_req_dn(far_req_dn), .far_tx_prof(far_tx_prof));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [3:0] mod_of(input logic [3:0] p);
        return (p <= 4'h9) ? p : p - 4'h1;
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
        cmp(g, e);
    endtask
    task automatic cmp_req(input logic [1:0] g, input logic [1:0] e);
        cmp(32'(g), 32'(e));
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    task automatic smp(input logic [7:0] m, input logic [7:0] b, input logic [1:0] e,
        input int w);
        if (e != 2'b00) rq_q.push_back(e);
        @(posedge clk_sys);
        mse_level <= m;
        ber_level <= b;
        mse_valid <= 1'b1;
        @(posedge clk_sys);
        mse_valid <= 1'b0;
        repeat (w) @(posedge clk_sys);
    endtask
    task automatic sof();
        repeat (3) @(posedge clk_sys);
        frame_sof <= 1'b1;
        @(posedge clk_sys);
        frame_sof <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic sof_chk(input logic [3:0] p, input logic [3:0] mx);
        sof();
        cmp(32'(tx_prof), 32'(p));
        cmp(32'(tx_mod), 32'(mod_of(p)));
        cmp(32'(tx_fec_light), 32'(p == 4'ha));
        cmp(32'(tx_pwr), 32'(pw[p]));
        cmp(32'(qos_drop), (mx - p > 4'h7) ? 32'd7 : 32'(mx - p));
        cmp(32'(fc_throttle), 32'(mx - p));
    endtask
    task automatic step(input logic up, input logic [3:0] p, input logic [3:0] mx);
        @(posedge clk_sys);
        slow <= 1'($urandom);
        send_up <= up;
        send_dn <= !up;
        @(posedge clk_sys);
        send_up <= 1'b0;
        send_dn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        sof_chk(p, mx);
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // results are matched in order as they appear at the outputs
    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        if (rd_d) cmp_rd(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
        if ((req_up || req_dn) !== 1'b0) begin
            cmp_req({req_dn, req_up}, rq_q.size() > 0 ? rq_q.pop_front() : 2'b00);
        end
    end

    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn, reg_wr, reg_rd, mse_valid, protect_active, frame_sof} = 6'h00;
        {send_up, send_dn, slow, bad, reg_addr, reg_wdata, mse_level, ber_level} = '0;
        errors = 0;
        checked = 0;
        void'($urandom(32'h31a9));
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(amp_pkg::OFF_CTRL, 32'h0, '1);
        rd(amp_pkg::OFF_PROF, 32'(amp_pkg::PROF_RST), '1);
        rd(amp_pkg::OFF_THR, 32'(amp_pkg::THR_RST), '1);
        rd(8'h20, 32'h0, '1);
        rd(8'h44, 32'h0, '1);
        for (int i = 0; i < 13; i++) begin
            pw[i] = 8'($urandom);
            wr(8'(8'h40 + 4 * i), {24'h0, pw[i]});
        end
        wr(amp_pkg::OFF_CTRL, 32'h80);
        for (int p = 0; p < 13; p++) begin
            wr(amp_pkg::OFF_PROF, 32'h0c00 | p);
            sof_chk(4'(p), 4'hc);
            cmp(32'(rx_prof), 32'(p));
        end
        wr(amp_pkg::OFF_CTRL, 32'h81);
        rd(amp_pkg::OFF_STAT, 32'h0, 32'h100);
        wr(amp_pkg::OFF_KEY, KEY_V ^ 32'h1);
        rd(amp_pkg::OFF_KEY, 32'h0, 32'h1);
        wr(amp_pkg::OFF_KEY, KEY_V);
        rd(amp_pkg::OFF_STAT, 32'h10c, 32'h10f);
        smp(8'hc0, 8'h00, 2'b00, 104);
        smp(8'hc1, 8'h00, 2'b01, 104);
        smp(8'h40, 8'h7f, 2'b00, 104);
        smp(8'h40, 8'h80, 2'b10, 104);
        smp(8'h3f, 8'h00, 2'b10, 0);
        smp(8'h3f, 8'h00, 2'b00, 104);
        smp(8'(8'h41 + $urandom % 127), 8'($urandom % 128), 2'b00, 104);
        wr(amp_pkg::OFF_CTRL, 32'h83);
        smp(8'h3f, 8'h00, 2'b00, 104);
        protect_active <= 1'b1;
        smp(8'h3f, 8'h00, 2'b10, 104);
        wr(amp_pkg::OFF_CTRL, 32'h80);
        smp(8'h3f, 8'h00, 2'b00, 104);
        cmp(32'(rq_q.size()), 32'h0);
        wr(amp_pkg::OFF_CTRL, 32'h81);
        protect_active <= 1'b0;
        sof();
        cmp(32'(rx_prof), 32'(far_tx_prof));
        cmp(32'(rx_mod), 32'(mod_of(far_tx_prof)));
        bad <= 1'b1;
        sof();
        cmp(32'(rx_prof), 32'h3);
        bad <= 1'b0;
        protect_active <= 1'b1;
        wr(amp_pkg::OFF_PROF, 32'h0b30);
        sof_chk(4'hb, 4'hb);
        step(1'b1, 4'hb, 4'hb);
        for (int i = 10; i >= 2; i--) step(1'b0, 4'(i < 3 ? 3 : i), 4'hb);
        for (int i = 4; i <= 11; i++) step(1'b1, 4'(i), 4'hb);
        wr(amp_pkg::OFF_PROF, 32'h0c00);
        wr(amp_pkg::OFF_CTRL, 32'h83);
        protect_active <= 1'b0;
        step(1'b1, 4'h0, 4'hc);
        wr(amp_pkg::OFF_CTRL, 32'h87);
        step(1'b1, 4'h1, 4'hc);
        for (int j = 0; j < 7; j++) begin
            wr(amp_pkg::OFF_CTRL, 32'(8'hf8 ^ (8'h01 << j)));
            repeat (3) @(posedge clk_sys);
            cmp(32'(xpic_alarm), 32'(j == 1 || j > 3));
        end
        rd(amp_pkg::OFF_STAT, 32'h200, 32'h200);
        repeat (4) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule // amp_ctrl_tb
